// *** rtl/pmtc_pkg.sv ***
package pmtc_pkg;
  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] REG_IDX_SLEEP_CFG = 8'hF0;
  localparam logic [7:0] REG_IDX_CLK_CFG = 8'hF1;
  localparam logic [11:0] ADDR_SLEEP_CFG = {2'h0, REG_IDX_SLEEP_CFG, 2'h0};
  localparam logic [11:0] ADDR_CLK_CFG = {2'h0, REG_IDX_CLK_CFG, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h000;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h004;
  localparam logic [11:0] ADDR_MODE = 12'h008;

  // sleep_mode_config fields
  localparam int SC1_STBY_BIT = 7;
  localparam int SC1_WAIT_LSB = 4;
  localparam int SC1_LOW_SPEED_FLAG_BIT = 3;
  localparam int SC1_MDIV_LSB = 0;
  localparam logic [7:0] SC1_RST = 8'h07;
  localparam logic [7:0] SC1_RSVD = 8'h04;

  // clock_transition_config fields
  localparam int SC2_NOISE_SAMPLE_SEL_BIT = 4;
  localparam int SC2_DIRECT_TRANSITION_FLAG_BIT = 3;
  localparam int SC2_MEDIUM_SPEED_FLAG_BIT = 2;
  localparam int SC2_SDIV_LSB = 0;
  localparam logic [7:0] SC2_RST = 8'hE0;
  localparam logic [7:0] SC2_RSVD = 8'hE0;

  // interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DT_BIT = 0;
  localparam int IRQ_LP_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // subactive clock division ratios
  localparam logic [3:0] SUB_DIV_8 = 4'h8;
  localparam logic [3:0] SUB_DIV_4 = 4'h4;
  localparam logic [3:0] SUB_DIV_2 = 4'h2;
  localparam logic [1:0] SDIV_SEL_8 = 2'h0;
  localparam logic [1:0] SDIV_SEL_4 = 2'h1;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PMTC_ACT_HIGH,
    PMTC_ACT_MED,
    PMTC_SUBACT,
    PMTC_SLEEP,
    PMTC_SUBSLEEP,
    PMTC_STANDBY,
    PMTC_WATCH
  } pmtc_mode_t;
endpackage

// *** rtl/pmtc_power_mode_ctrl.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Operation
// - standby select clear: sleep takes active to sleep, subactive to subsleep.
// - standby select set: active goes to standby or watch, subactive to watch.
// - medium-speed flag picks high-speed or medium-speed active operation.
// - two-bit field sets subactive clock to watch clock over 8, 4 or 2.
// - direct flag clear: ordinary sleep transitions only.
// - direct from high-speed: to medium-speed or subactive under listed bit settings.
// - direct from medium-speed: to high-speed or subactive under listed bit settings.
// - direct from subactive to high-speed when standby, timer bit set, low-speed clear.
// - same jump goes to medium-speed instead when medium-speed flag is set.
// - direct transition sets the direct-transition interrupt flag; software clears it.
module pmtc_power_mode_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sleep,
  input wire logic i_wakeup,
  input wire logic i_timer_clock_bit,
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [2:0] o_mode,
  output logic o_sys_clk_run,
  output logic o_medium_speed,
  output logic [3:0] o_sub_div_ratio,
  output logic [1:0] o_medium_clk_div,
  output logic [2:0] o_wake_wait_sel,
  output logic o_noise_sample_sel,
  output logic o_irq
);

  logic [7:0] sleep_cfg_reg;
  logic [7:0] clk_cfg_reg;
  logic [pmtc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [pmtc_pkg::IRQ_W-1:0] irq_stat_next;
  logic [pmtc_pkg::IRQ_W-1:0] irq_mask_reg;
  pmtc_pkg::pmtc_mode_t mode_reg;
  pmtc_pkg::pmtc_mode_t mode_next;

  logic aw_hold_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [3:0] sub_div_reg;

  // ---------------- register bus ----------------
  wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire aw_take = i_s_axi_awvalid & o_s_axi_awready;
  wire w_take = i_s_axi_wvalid & o_s_axi_wready;
  wire ar_take = i_s_axi_arvalid & o_s_axi_arready;
  wire [11:0] waddr = 12'(aw_addr_reg);
  wire [11:0] raddr = 12'(i_s_axi_araddr);
  wire wr_lane0 = do_write & w_strb_reg[0];
  wire wr_sleep_cfg = wr_lane0 & (waddr == pmtc_pkg::ADDR_SLEEP_CFG);
  wire wr_clk_cfg = wr_lane0 & (waddr == pmtc_pkg::ADDR_CLK_CFG);
  wire wr_irq_stat = wr_lane0 & (waddr == pmtc_pkg::ADDR_IRQ_STAT);
  wire wr_irq_mask = wr_lane0 & (waddr == pmtc_pkg::ADDR_IRQ_MASK);
  wire w_mapped = (waddr == pmtc_pkg::ADDR_SLEEP_CFG) | (waddr == pmtc_pkg::ADDR_CLK_CFG) |
                  (waddr == pmtc_pkg::ADDR_IRQ_STAT) | (waddr == pmtc_pkg::ADDR_IRQ_MASK) |
                  (waddr == pmtc_pkg::ADDR_MODE);
  wire r_mapped = (raddr == pmtc_pkg::ADDR_SLEEP_CFG) | (raddr == pmtc_pkg::ADDR_CLK_CFG) |
                  (raddr == pmtc_pkg::ADDR_IRQ_STAT) | (raddr == pmtc_pkg::ADDR_IRQ_MASK) |
                  (raddr == pmtc_pkg::ADDR_MODE);
  wire [31:0] rd_value =
    (raddr == pmtc_pkg::ADDR_SLEEP_CFG) ? {24'h0, sleep_cfg_reg} :
    (raddr == pmtc_pkg::ADDR_CLK_CFG) ? {24'h0, clk_cfg_reg} :
    (raddr == pmtc_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
    (raddr == pmtc_pkg::ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
    (raddr == pmtc_pkg::ADDR_MODE) ? {29'h0, mode_reg} : 32'h0;

  assign o_s_axi_awready = ~aw_hold_reg;
  assign o_s_axi_wready = ~w_hold_reg;
  assign o_s_axi_arready = ~rvalid_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= i_s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= i_s_axi_wdata;
      w_strb_reg <= i_s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= pmtc_pkg::AXI_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_mapped ? pmtc_pkg::AXI_OKAY : pmtc_pkg::AXI_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= pmtc_pkg::AXI_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= r_mapped ? pmtc_pkg::AXI_OKAY : pmtc_pkg::AXI_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- configuration registers ----------------
  // a sleep in the same cycle as a config write sees the old values
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_cfg_reg <= pmtc_pkg::SC1_RST;
      clk_cfg_reg <= pmtc_pkg::SC2_RST;
      irq_mask_reg <= pmtc_pkg::IRQ_MASK_RST;
    end else begin
      if (wr_sleep_cfg) begin
        sleep_cfg_reg <= w_data_reg[7:0] | pmtc_pkg::SC1_RSVD;
      end
      if (wr_clk_cfg) begin
        clk_cfg_reg <= w_data_reg[7:0] | pmtc_pkg::SC2_RSVD;
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= w_data_reg[pmtc_pkg::IRQ_W-1:0];
      end
    end
  end

  wire stby = sleep_cfg_reg[pmtc_pkg::SC1_STBY_BIT];
  wire low_speed_flag = sleep_cfg_reg[pmtc_pkg::SC1_LOW_SPEED_FLAG_BIT];
  wire direct_transition_flag = clk_cfg_reg[pmtc_pkg::SC2_DIRECT_TRANSITION_FLAG_BIT];
  wire medium_speed_flag = clk_cfg_reg[pmtc_pkg::SC2_MEDIUM_SPEED_FLAG_BIT];
  wire [1:0] sdiv = clk_cfg_reg[pmtc_pkg::SC2_SDIV_LSB +: 2];
  wire tmb = i_timer_clock_bit;

  // ---------------- mode transitions ----------------
  wire in_active = (mode_reg == pmtc_pkg::PMTC_ACT_HIGH) | (mode_reg == pmtc_pkg::PMTC_ACT_MED);
  wire in_run = in_active | (mode_reg == pmtc_pkg::PMTC_SUBACT);
  wire sleep_go = i_sleep & in_run;
  wire to_sub = stby & tmb & low_speed_flag;
  wire hi_to_med = ~stby & medium_speed_flag & ~low_speed_flag;
  wire med_to_hi = ~stby & ~medium_speed_flag & ~low_speed_flag;
  wire sub_to_act = stby & tmb & ~low_speed_flag;
  wire pmtc_pkg::pmtc_mode_t act_mode = medium_speed_flag ? pmtc_pkg::PMTC_ACT_MED : pmtc_pkg::PMTC_ACT_HIGH;
  wire direct_ok =
    direct_transition_flag & (((mode_reg == pmtc_pkg::PMTC_ACT_HIGH) & (hi_to_med | to_sub)) |
            ((mode_reg == pmtc_pkg::PMTC_ACT_MED) & (med_to_hi | to_sub)) |
            ((mode_reg == pmtc_pkg::PMTC_SUBACT) & sub_to_act));
  wire dt_event = sleep_go & direct_ok;
  wire lp_event = sleep_go & ~direct_ok;
  wire wake_go = i_wakeup & ~in_run;

  always_comb begin
    mode_next = mode_reg;
    if (dt_event) begin
      case (mode_reg)
        pmtc_pkg::PMTC_ACT_HIGH: begin
          mode_next = to_sub ? pmtc_pkg::PMTC_SUBACT : pmtc_pkg::PMTC_ACT_MED;
        end
        pmtc_pkg::PMTC_ACT_MED: begin
          mode_next = to_sub ? pmtc_pkg::PMTC_SUBACT : pmtc_pkg::PMTC_ACT_HIGH;
        end
        pmtc_pkg::PMTC_SUBACT: begin
          mode_next = act_mode;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end else if (lp_event) begin
      // ordinary sleep, also the fallback when direct conditions fail
      if (in_active) begin
        if (stby) begin
          mode_next = tmb ? pmtc_pkg::PMTC_WATCH : pmtc_pkg::PMTC_STANDBY;
        end else begin
          mode_next = pmtc_pkg::PMTC_SLEEP;
        end
      end else begin
        mode_next = stby ? pmtc_pkg::PMTC_WATCH : pmtc_pkg::PMTC_SUBSLEEP;
      end
    end else if (wake_go) begin
      case (mode_reg)
        pmtc_pkg::PMTC_SUBSLEEP: begin
          mode_next = pmtc_pkg::PMTC_SUBACT;
        end
        pmtc_pkg::PMTC_WATCH: begin
          mode_next = low_speed_flag ? pmtc_pkg::PMTC_SUBACT : act_mode;
        end
        pmtc_pkg::PMTC_SLEEP, pmtc_pkg::PMTC_STANDBY: begin
          mode_next = act_mode;
        end
        default: begin
          mode_next = mode_reg;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= pmtc_pkg::PMTC_ACT_HIGH;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ---------------- interrupts ----------------
  // write one to clear; an event in the clearing cycle still sets the bit
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_irq_stat) begin
      irq_stat_next = irq_stat_reg & ~w_data_reg[pmtc_pkg::IRQ_W-1:0];
    end
    irq_stat_next[pmtc_pkg::IRQ_DT_BIT] = irq_stat_next[pmtc_pkg::IRQ_DT_BIT] | dt_event;
    irq_stat_next[pmtc_pkg::IRQ_LP_BIT] = irq_stat_next[pmtc_pkg::IRQ_LP_BIT] | lp_event;
    irq_stat_next[pmtc_pkg::IRQ_WAKE_BIT] = irq_stat_next[pmtc_pkg::IRQ_WAKE_BIT] | wake_go;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      o_irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ---------------- clock controls ----------------
  wire [3:0] sub_div_next = (sdiv == pmtc_pkg::SDIV_SEL_8) ? pmtc_pkg::SUB_DIV_8 :
                            (sdiv == pmtc_pkg::SDIV_SEL_4) ? pmtc_pkg::SUB_DIV_4 :
                            pmtc_pkg::SUB_DIV_2;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sub_div_reg <= pmtc_pkg::SUB_DIV_8;
    end else begin
      sub_div_reg <= sub_div_next;
    end
  end

  assign o_mode = mode_reg;
  assign o_sys_clk_run = in_active;
  assign o_medium_speed = (mode_reg == pmtc_pkg::PMTC_ACT_MED);
  assign o_sub_div_ratio = sub_div_reg;
  assign o_medium_clk_div = sleep_cfg_reg[pmtc_pkg::SC1_MDIV_LSB +: 2];
  assign o_wake_wait_sel = sleep_cfg_reg[pmtc_pkg::SC1_WAIT_LSB +: 3];
  assign o_noise_sample_sel = clk_cfg_reg[pmtc_pkg::SC2_NOISE_SAMPLE_SEL_BIT];

endmodule

// *** test/pmtc_power_mode_ctrl_asserts.sv ***
`timescale 1ns/1ps
module pmtc_power_mode_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sleep,
  input wire logic i_wakeup,
  input wire logic i_s_axi_bready,
  input wire logic o_s_axi_bvalid,
  input wire logic [2:0] o_mode,
  input wire logic o_sys_clk_run,
  input wire logic o_medium_speed,
  input wire logic [3:0] o_sub_div_ratio
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_run_sleep;
    (o_mode <= 3'h2) && i_sleep;
  endsequence
  a_sleep_moves: assert property (s_run_sleep |=> o_mode != $past(o_mode))
    else $error("sleep left the mode unchanged");
  a_sub_targets: assert property ((o_mode == 3'h2) && i_sleep |=> o_mode inside {0, 1, 4, 6})
    else $error("bad mode after sleep in subactive");
  a_act_targets: assert property ((o_mode <= 3'h1) && i_sleep |=> o_mode != 3'h4)
    else $error("active mode entered subsleep");
  a_lp_refuse: assert property ((o_mode >= 3'h3) && i_sleep && !i_wakeup |=> $stable(o_mode))
    else $error("sleep acted in a low-power mode");
  a_idle_stable: assert property (!i_sleep && !i_wakeup |=> $stable(o_mode))
    else $error("mode changed without an event");
  a_run_clock: assert property (o_sys_clk_run == (o_mode <= 3'h1))
    else $error("system clock run flag wrong");
  a_med_flag: assert property (o_medium_speed == (o_mode == 3'h1))
    else $error("medium speed flag wrong");
  a_sub_ratio: assert property (o_sub_div_ratio inside {4'h8, 4'h4, 4'h2})
    else $error("subactive ratio out of range");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped early");
endmodule
bind pmtc_power_mode_ctrl pmtc_power_mode_ctrl_asserts chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sleep(i_sleep), .i_wakeup(i_wakeup), .i_s_axi_bready(i_s_axi_bready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_mode(o_mode), .o_sys_clk_run(o_sys_clk_run),
  .o_medium_speed(o_medium_speed), .o_sub_div_ratio(o_sub_div_ratio));

// *** test/pmtc_cpu_model.sv ***
`timescale 1ns/1ps
module pmtc_cpu_model (
  input wire logic i_clk,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  output logic [11:0] o_awaddr,
  output logic o_awvalid,
  output logic [31:0] o_wdata,
  output logic o_wvalid,
  output logic o_bready,
  output logic [11:0] o_araddr,
  output logic o_arvalid,
  output logic o_rready,
  output logic o_sleep,
  output logic o_wakeup,
  output logic o_tmb
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready, o_sleep, o_wakeup, o_tmb} = '0;
  end
  // late holds bready back until bvalid shows, so the slave must keep its answer standing
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic late,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_awvalid <= 1'h1;
    o_wvalid <= 1'h1;
    o_bready <= !late;
    do begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'h0;
      if (o_wvalid && i_wready) o_wvalid <= 1'h0;
      if (i_bvalid && !o_bready) o_bready <= 1'h1;
    end while (!(i_bvalid && o_bready));
    r = i_bresp;
    o_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    o_araddr <= a;
    o_arvalid <= 1'h1;
    o_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'h0;
    end while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'h0;
  endtask
  // config is written before the pulse since the block uses values at the pulse
  task automatic pulse(input logic slp, input logic t);
    @(posedge i_clk);
    o_tmb <= t;
    o_sleep <= slp;
    o_wakeup <= !slp;
    @(posedge i_clk);
    o_sleep <= 1'h0;
    o_wakeup <= 1'h0;
  endtask
endmodule

// *** test/power_mode_transition_control_tb.sv ***
`timescale 1ns/1ps
module power_mode_transition_control_tb;
  localparam logic [11:0] A1 = pmtc_pkg::ADDR_SLEEP_CFG;
  localparam logic [11:0] A2 = pmtc_pkg::ADDR_CLK_CFG;
  localparam logic [11:0] AS = pmtc_pkg::ADDR_IRQ_STAT;
  localparam logic [11:0] AM = pmtc_pkg::ADDR_IRQ_MASK;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic awrdy, wrdy, bvld, arrdy, rvld, slp, wak, tmb, irq, awvld, wvld, brdy, arvld, rrdy;
  logic srun, mspd, nsel;
  logic [1:0] bresp, rresp, r, mdiv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [2:0] mode, wsel;
  logic [3:0] sdiv;
  int fail_count = 0;
  int checks = 0;
  always #2 i_clk = ~i_clk;
  pmtc_power_mode_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sleep(slp), .i_wakeup(wak),
    .i_timer_clock_bit(tmb), .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0),
    .i_s_axi_awvalid(awvld), .o_s_axi_awready(awrdy), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvld), .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvld), .i_s_axi_bready(brdy), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
    .i_s_axi_arvalid(arvld), .o_s_axi_arready(arrdy), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvld), .i_s_axi_rready(rrdy), .o_mode(mode),
    .o_sys_clk_run(srun), .o_medium_speed(mspd), .o_sub_div_ratio(sdiv),
    .o_medium_clk_div(mdiv), .o_wake_wait_sel(wsel), .o_noise_sample_sel(nsel), .o_irq(irq));
  pmtc_cpu_model cpu_u (.i_clk(i_clk), .i_awready(awrdy), .i_wready(wrdy), .i_bvalid(bvld),
    .i_bresp(bresp), .i_arready(arrdy), .i_rvalid(rvld), .i_rdata(rdat), .i_rresp(rresp),
    .o_awaddr(awa), .o_awvalid(awvld), .o_wdata(wd), .o_wvalid(wvld), .o_bready(brdy),
    .o_araddr(ara), .o_arvalid(arvld), .o_rready(rrdy), .o_sleep(slp), .o_wakeup(wak),
    .o_tmb(tmb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    cpu_u.rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] v);
    cpu_u.wr(a, v, 1'h0, r);
    chk({30'h0, r}, {30'h0, pmtc_pkg::AXI_OKAY});
    @(negedge i_clk);
  endtask
  task automatic step(input logic [7:0] s1, s2, input logic t, s, input logic [2:0] e);
    w(A1, {24'h0, s1});
    w(A2, {24'h0, s2});
    cpu_u.pulse(s, t);
    @(negedge i_clk);
    chk({29'h0, mode}, {29'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    rchk(A1, 32'h07, 2'h0);
    rchk(A2, 32'hE0, 2'h0);
    rchk(AM, 32'h0, 2'h0);
    chk({24'h0, srun, mspd, mdiv, wsel, nsel}, 32'hB0);
    rchk(12'h100, 32'h0, 2'h2);
    cpu_u.wr(12'h100, 32'h1, 1'h1, r);
    chk({30'h0, r}, 32'h2);
    w(AM, 32'h1);
    step(8'h00, 8'h00, 1'h0, 1'h1, 3'h3);
    chk({30'h0, srun, mspd}, 32'h0);
    step(8'h00, 8'h00, 1'h0, 1'h0, 3'h0);
    step(8'h80, 8'h00, 1'h0, 1'h1, 3'h5);
    step(8'h80, 8'h00, 1'h1, 1'h0, 3'h0);
    step(8'h80, 8'h00, 1'h1, 1'h1, 3'h6);
    step(8'h80, 8'h00, 1'h1, 1'h0, 3'h0);
    step(8'h00, 8'h08, 1'h0, 1'h1, 3'h3);
    step(8'h00, 8'h08, 1'h0, 1'h0, 3'h0);
    rchk(AS, 32'h6, 2'h0);
    w(AS, 32'h7);
    step(8'h00, 8'h0C, 1'h0, 1'h1, 3'h1);
    chk({30'h0, srun, mspd}, 32'h3);
    chk({31'h0, irq}, 32'h1);
    rchk(AS, 32'h1, 2'h0);
    rchk(A2, 32'hEC, 2'h0);
    w(AS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    w(AM, 32'h0);
    step(8'h00, 8'h08, 1'h0, 1'h1, 3'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(AS, 32'h1, 2'h0);
    w(AM, 32'h1);
    chk({31'h0, irq}, 32'h1);
    w(AS, 32'h1);
    step(8'h88, 8'h08, 1'h1, 1'h1, 3'h2);
    step(8'h08, 8'h00, 1'h0, 1'h1, 3'h4);
    step(8'h08, 8'h00, 1'h0, 1'h0, 3'h2);
    step(8'h88, 8'h00, 1'h0, 1'h1, 3'h6);
    step(8'h88, 8'h00, 1'h0, 1'h0, 3'h2);
    step(8'h80, 8'h0C, 1'h1, 1'h1, 3'h1);
    step(8'h88, 8'h0C, 1'h1, 1'h1, 3'h2);
    step(8'h80, 8'h08, 1'h1, 1'h1, 3'h0);
    rchk(A1, 32'h84, 2'h0);
    rchk(pmtc_pkg::ADDR_MODE, 32'h0, 2'h0);
    w(A1, 32'h72);
    w(A2, 32'h10);
    chk({24'h0, srun, mspd, mdiv, wsel, nsel}, 32'hAF);
    for (int i = 0; i < 3; i++) begin
      w(A2, 32'(i));
      chk({28'h0, sdiv}, {28'h0, 4'h8 >> i});
    end
    test_done();
  end
endmodule
